/* dss_pkg.sv */
// Constants for the DMA suspend and state support block
package dss_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACTIVITY = 8'h84;
  localparam logic [7:0] IDX_CTRL_TEN = 8'hD6;
  localparam logic [7:0] IDX_SRC_FOUR = 8'hDD;
  localparam int ADDR_SHIFT = 2;
  // Field positions
  localparam int CTRL_TRAP_EN_BIT = 6;
  localparam int CTRL_PTR_LOW_BIT = 5;
  localparam int CTRL_SAMPLE_SEL_BIT = 3;
  localparam int ACT_PTR_HIGH_BIT = 4;
  localparam int SRC_TRAP_EVT_BIT = 4;
  localparam int MODE_AUTOINIT_BIT = 4;
  localparam int MODE_DECREMENT_BIT = 5;
  // System I/O ports of the two controllers
  localparam logic [9:0] IO_LOW_MASK_SINGLE = 10'h00A;
  localparam logic [9:0] IO_LOW_MODE = 10'h00B;
  localparam logic [9:0] IO_LOW_PTR_CLR = 10'h00C;
  localparam logic [9:0] IO_LOW_MASTER_CLR = 10'h00D;
  localparam logic [9:0] IO_LOW_RB_RESET = 10'h00E;
  localparam logic [9:0] IO_LOW_MASK_ALL = 10'h00F;
  localparam logic [9:0] IO_HIGH_MASK_SINGLE = 10'h0D4;
  localparam logic [9:0] IO_HIGH_MODE = 10'h0D6;
  localparam logic [9:0] IO_HIGH_PTR_CLR = 10'h0D8;
  localparam logic [9:0] IO_HIGH_MASTER_CLR = 10'h0DA;
  localparam logic [9:0] IO_HIGH_RB_RESET = 10'h0DC;
  localparam logic [9:0] IO_HIGH_MASK_ALL = 10'h0DE;
  localparam logic [9:0] IO_HIGH_REG_BASE = 10'h0C0;
  // Mask reset value; count left after a terminal count without autoinit
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [15:0] COUNT_DONE = 16'hFFFF;
endpackage

/* dss_top.sv */
// DMA suspend support: trap, progress flags, pointer shadows, readback, local-bus sampling
module dss_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [9:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  input wire logic [7:0] dma_request_in,
  input wire logic [7:0] dma_step_in,
  output logic [7:0] dma_request_out,
  output logic [7:0] terminal_count_out,
  output logic dma_halt_out,
  output logic mgmt_interrupt_out,
  input wire logic dma_local_cycle_in,
  input wire logic local_device_claim_n_in,
  output logic address_strobe_n_out,
  output logic data_buffer_en_out
);
  import dss_pkg::*;

  typedef struct packed {
    logic trap_en;
    logic sample_sel;
    logic trap_evt;
    logic [7:0] inprog;
    logic [7:0] armed;
    logic [7:0] mask;
    logic [7:0][7:0] mode;
    logic [1:0] ptr;
    logic [1:0][1:0] rb_cnt;
    logic [7:0][15:0] base_adr;
    logic [7:0][15:0] cur_adr;
    logic [7:0][15:0] base_cnt;
    logic [7:0][15:0] cur_cnt;
    logic [7:0] tc;
    logic [7:0] io_rdata;
    logic [31:0] prdata;
    logic local_prev;
    logic strobe_n;
    logic buf_en;
  } dss_state_s;

  dss_state_s state_q;
  dss_state_s state_d;

  // Decode a channel address/count port: {hit, is_count, channel}
  function automatic logic [4:0] dss_chan_port(input logic [9:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a[9:3] == 7'h00)
    begin
      r = {1'b1, a[0], 1'b0, a[2:1]};
    end
    else if (a[9:4] == IO_HIGH_REG_BASE[9:4] && !a[0])
    begin
      r = {1'b1, a[1], 1'b1, a[3:2]};
    end
    return r;
  endfunction

  logic apb_setup;
  logic apb_write;
  logic [9:0] reg_idx;
  logic reg_hit;
  logic [4:0] cport;
  logic [2:0] cch;
  logic cctl;
  logic [7:0] active_req;

  assign apb_setup = psel_in && !penable_in;
  assign apb_write = psel_in && penable_in && pwrite_in;
  assign reg_idx = paddr_in[11:ADDR_SHIFT];
  assign reg_hit = paddr_in[1:0] == 2'h0 && reg_idx[9:8] == 2'h0
    && (reg_idx[7:0] == IDX_ACTIVITY || reg_idx[7:0] == IDX_CTRL_TEN
    || reg_idx[7:0] == IDX_SRC_FOUR);
  assign cport = dss_chan_port(io_addr_in);
  assign cch = cport[2:0];
  assign cctl = cport[2];
  // Masked requests never reach the engine
  assign active_req = dma_request_in & ~state_q.mask;

  always_comb
  begin
    logic [7:0] byte_v;
    logic [2:0] ch;
    logic unmask_ev;
    byte_v = 8'h00;
    ch = 3'h0;
    unmask_ev = 1'b0;
    state_d = state_q;
    state_d.tc = 8'h00;

    // APB register writes
    if (apb_write && reg_hit)
    begin
      if (reg_idx[7:0] == IDX_CTRL_TEN)
      begin
        state_d.trap_en = pwdata_in[CTRL_TRAP_EN_BIT];
        state_d.sample_sel = pwdata_in[CTRL_SAMPLE_SEL_BIT];
      end
      else if (reg_idx[7:0] == IDX_SRC_FOUR && pwdata_in[SRC_TRAP_EVT_BIT])
      begin
        state_d.trap_evt = 1'b0;
      end
    end
    // Set after clear so a new trap is never lost
    if (state_q.trap_en && |dma_request_in)
    begin
      state_d.trap_evt = 1'b1;
    end

    // APB read data staged in setup so it is stable in access
    if (apb_setup)
    begin
      state_d.prdata = 32'h0000_0000;
      if (reg_idx[7:0] == IDX_ACTIVITY && reg_hit)
      begin
        state_d.prdata[7:0] = {state_q.inprog[7:5], state_q.ptr[1], state_q.inprog[3:0]};
      end
      else if (reg_idx[7:0] == IDX_CTRL_TEN && reg_hit)
      begin
        state_d.prdata[CTRL_TRAP_EN_BIT] = state_q.trap_en;
        state_d.prdata[CTRL_PTR_LOW_BIT] = state_q.ptr[0];
        state_d.prdata[CTRL_SAMPLE_SEL_BIT] = state_q.sample_sel;
      end
      else if (reg_idx[7:0] == IDX_SRC_FOUR && reg_hit)
      begin
        state_d.prdata[SRC_TRAP_EVT_BIT] = state_q.trap_evt;
      end
    end

    // System I/O writes to the controllers
    if (io_wr_in)
    begin
      if (cport[4])
      begin
        if (cport[3])
        begin
          if (state_q.ptr[cctl])
          begin
            state_d.base_cnt[cch][15:8] = io_wdata_in;
            state_d.cur_cnt[cch][15:8] = io_wdata_in;
          end
          else
          begin
            state_d.base_cnt[cch][7:0] = io_wdata_in;
            state_d.cur_cnt[cch][7:0] = io_wdata_in;
          end
        end
        else
        begin
          if (state_q.ptr[cctl])
          begin
            state_d.base_adr[cch][15:8] = io_wdata_in;
            state_d.cur_adr[cch][15:8] = io_wdata_in;
          end
          else
          begin
            state_d.base_adr[cch][7:0] = io_wdata_in;
            state_d.cur_adr[cch][7:0] = io_wdata_in;
          end
        end
        state_d.ptr[cctl] = ~state_q.ptr[cctl];
      end
      else if (io_addr_in == IO_LOW_MODE)
      begin
        state_d.mode[{1'b0, io_wdata_in[1:0]}] = io_wdata_in;
      end
      else if (io_addr_in == IO_HIGH_MODE)
      begin
        state_d.mode[{1'b1, io_wdata_in[1:0]}] = io_wdata_in;
      end
      else if (io_addr_in == IO_LOW_PTR_CLR)
      begin
        state_d.ptr[0] = 1'b0;
      end
      else if (io_addr_in == IO_HIGH_PTR_CLR)
      begin
        state_d.ptr[1] = 1'b0;
      end
      else if (io_addr_in == IO_LOW_MASK_SINGLE)
      begin
        state_d.mask[{1'b0, io_wdata_in[1:0]}] = io_wdata_in[2];
      end
      else if (io_addr_in == IO_HIGH_MASK_SINGLE)
      begin
        state_d.mask[{1'b1, io_wdata_in[1:0]}] = io_wdata_in[2];
      end
      else if (io_addr_in == IO_LOW_MASK_ALL)
      begin
        state_d.mask[3:0] = io_wdata_in[3:0];
      end
      else if (io_addr_in == IO_HIGH_MASK_ALL)
      begin
        state_d.mask[7:4] = io_wdata_in[3:0];
      end
      else if (io_addr_in == IO_LOW_RB_RESET)
      begin
        state_d.mask[3:0] = 4'h0;
      end
      else if (io_addr_in == IO_HIGH_RB_RESET)
      begin
        state_d.mask[7:4] = 4'h0;
      end
      else if (io_addr_in == IO_LOW_MASTER_CLR)
      begin
        state_d.mask[3:0] = MASK_RESET[3:0];
        state_d.ptr[0] = 1'b0;
      end
      else if (io_addr_in == IO_HIGH_MASTER_CLR)
      begin
        state_d.mask[7:4] = MASK_RESET[7:4];
        state_d.ptr[1] = 1'b0;
      end
    end

    // System I/O reads: data appears one cycle after the strobe
    if (io_rd_in)
    begin
      if (cport[4])
      begin
        // Base values are write-only; reads see the live copy
        if (cport[3])
        begin
          byte_v = state_q.ptr[cctl] ? state_q.cur_cnt[cch][15:8]
            : state_q.cur_cnt[cch][7:0];
        end
        else
        begin
          byte_v = state_q.ptr[cctl] ? state_q.cur_adr[cch][15:8]
            : state_q.cur_adr[cch][7:0];
        end
        state_d.ptr[cctl] = ~state_q.ptr[cctl];
      end
      else if (io_addr_in == IO_LOW_RB_RESET)
      begin
        state_d.rb_cnt[0] = 2'h0;
      end
      else if (io_addr_in == IO_HIGH_RB_RESET)
      begin
        state_d.rb_cnt[1] = 2'h0;
      end
      else if (io_addr_in == IO_LOW_MODE)
      begin
        byte_v = state_q.mode[{1'b0, state_q.rb_cnt[0]}];
        state_d.rb_cnt[0] = state_q.rb_cnt[0] + 2'h1;
      end
      else if (io_addr_in == IO_HIGH_MODE)
      begin
        byte_v = state_q.mode[{1'b1, state_q.rb_cnt[1]}];
        state_d.rb_cnt[1] = state_q.rb_cnt[1] + 2'h1;
      end
      else if (io_addr_in == IO_LOW_MASK_ALL)
      begin
        byte_v = {4'h0, state_q.mask[3:0]};
      end
      else if (io_addr_in == IO_HIGH_MASK_ALL)
      begin
        byte_v = {4'h0, state_q.mask[7:4]};
      end
      else if (io_addr_in == IO_LOW_PTR_CLR)
      begin
        state_d.ptr[0] = 1'b1;
      end
      else if (io_addr_in == IO_HIGH_PTR_CLR)
      begin
        state_d.ptr[1] = 1'b1;
      end
      state_d.io_rdata = byte_v;
    end

    // Transfer steps; frozen while halted so saved state stays exact
    for (int i = 0; i < 8; i++)
    begin
      ch = 3'(i);
      if (dma_step_in[i] && !dma_halt_out)
      begin
        state_d.cur_adr[ch] = state_q.mode[ch][MODE_DECREMENT_BIT]
          ? state_q.cur_adr[ch] - 16'h0001 : state_q.cur_adr[ch] + 16'h0001;
        if (state_q.cur_cnt[ch] == 16'h0000)
        begin
          state_d.tc[ch] = 1'b1;
          if (state_q.mode[ch][MODE_AUTOINIT_BIT])
          begin
            state_d.cur_cnt[ch] = state_q.base_cnt[ch];
            state_d.cur_adr[ch] = state_q.base_adr[ch];
          end
          else
          begin
            state_d.cur_cnt[ch] = COUNT_DONE;
            state_d.mask[ch] = 1'b1;
          end
        end
        else
        begin
          state_d.cur_cnt[ch] = state_q.cur_cnt[ch] - 16'h0001;
        end
      end
      // Arm on an unmask edge, fire on the next request
      unmask_ev = state_q.mask[ch] && !state_d.mask[ch];
      if (state_q.armed[ch] && active_req[ch])
      begin
        state_d.inprog[ch] = 1'b1;
        state_d.armed[ch] = 1'b0;
      end
      if (unmask_ev)
      begin
        state_d.armed[ch] = 1'b1;
      end
      if (state_d.tc[ch])
      begin
        state_d.inprog[ch] = 1'b0;
      end
    end

    // Local-bus DMA: own strobe, then buffer enable on claim sampled in the strobe, or from cycle start with sample_sel
    state_d.local_prev = dma_local_cycle_in;
    state_d.strobe_n = !(dma_local_cycle_in && !state_q.local_prev);
    if (!dma_local_cycle_in)
    begin
      state_d.buf_en = 1'b0;
    end
    else if (state_q.sample_sel && !local_device_claim_n_in)
    begin
      state_d.buf_en = 1'b1;
    end
    else if (!state_q.sample_sel && !local_device_claim_n_in && !state_q.strobe_n)
    begin
      state_d.buf_en = 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_q <= '0;
      state_q.mask <= MASK_RESET;
      state_q.strobe_n <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Enable alone halts and blocks; a pending event also holds the halt
  assign dma_halt_out = state_q.trap_en || state_q.trap_evt;
  assign dma_request_out = active_req & ~{8{dma_halt_out}};
  assign mgmt_interrupt_out = state_q.trap_evt;
  assign terminal_count_out = state_q.tc;
  assign io_rdata_out = state_q.io_rdata;
  assign prdata_out = state_q.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !reg_hit;
  assign address_strobe_n_out = state_q.strobe_n;
  assign data_buffer_en_out = state_q.buf_en;
endmodule

/* dss_monitor.sv */
// Port-level assertions for the DMA suspend support block
module dss_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] dma_step_in,
  input wire logic [7:0] dma_request_out,
  input wire logic [7:0] terminal_count_out,
  input wire logic dma_halt_out,
  input wire logic mgmt_interrupt_out,
  input wire logic dma_local_cycle_in,
  input wire logic local_device_claim_n_in,
  input wire logic address_strobe_n_out,
  input wire logic data_buffer_en_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_halt_gates_req: assert property (dma_halt_out |-> dma_request_out == 8'h00)
    else $error("request passed while halted");
  a_irq_keeps_halt: assert property (mgmt_interrupt_out |-> dma_halt_out)
    else $error("interrupt without halt");
  a_halt_no_tc: assert property (dma_halt_out |=> terminal_count_out == 8'h00)
    else $error("count advanced while halted");
  a_tc_from_step: assert property ((terminal_count_out & ~$past(dma_step_in)) == 8'h00)
    else $error("terminal count without step");
  a_strobe_pulse: assert property ($rose(dma_local_cycle_in) |=>
    !address_strobe_n_out ##1 address_strobe_n_out)
    else $error("strobe not a one cycle pulse");
  a_strobe_cause: assert property (!address_strobe_n_out |->
    $past(dma_local_cycle_in) && !$past(dma_local_cycle_in, 2))
    else $error("strobe without cycle start");
  a_buf_drop: assert property ($fell(dma_local_cycle_in) |=> !data_buffer_en_out)
    else $error("buffer held after cycle");
  a_buf_needs_claim: assert property ($rose(data_buffer_en_out) |->
    !$past(local_device_claim_n_in) && $past(dma_local_cycle_in))
    else $error("buffer enabled without claim");
endmodule

bind dss_top dss_monitor i_dss_monitor (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .dma_step_in(dma_step_in),
  .dma_request_out(dma_request_out),
  .terminal_count_out(terminal_count_out),
  .dma_halt_out(dma_halt_out),
  .mgmt_interrupt_out(mgmt_interrupt_out),
  .dma_local_cycle_in(dma_local_cycle_in),
  .local_device_claim_n_in(local_device_claim_n_in),
  .address_strobe_n_out(address_strobe_n_out),
  .data_buffer_en_out(data_buffer_en_out)
);

/* dss_periph_model.sv */
// Far side model: DMA peripherals and a local-bus target
module dss_periph_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] want_in,
  input wire logic [7:0] terminal_count_in,
  input wire logic dma_local_cycle_in,
  input wire logic [1:0] claim_delay_in,
  output logic [7:0] dma_request_out,
  output logic local_device_claim_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] served;
  logic [1:0] age;
  // Served device stops asking until the bench withdraws its want
  assign dma_request_out = want_in & ~served;
  // Claim line idles high; decode may lag the cycle start
  assign local_device_claim_n_out = !(dma_local_cycle_in && age >= claim_delay_in);
  always @(posedge clk_in)
  begin
    served <= rst_in ? 8'h00 : (served | terminal_count_in) & want_in;
    age <= !dma_local_cycle_in ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
  end
endmodule

/* tb_dss_top.sv */
// Self-checking bench for the DMA suspend support block
module tb_dss_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;
  typedef struct {int k; logic [11:0] a; logic [7:0] d;} dss_row_s;
  logic clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, er, dma_halt_out, mgmt_interrupt_out;
  logic io_rd_in = 1'b0, io_wr_in = 1'b0, dma_local_cycle_in = 1'b0;
  logic [9:0] io_addr_in = 10'h000;
  logic [7:0] io_wdata_in = 8'h00, io_rdata_out, dma_step_in = 8'h00, want = 8'h02;
  logic [7:0] dma_request_in, dma_request_out, terminal_count_out;
  logic local_device_claim_n_in, address_strobe_n_out, data_buffer_en_out;
  int errors = 0, checks_done = 0, cycles = 0, n;
  int nl [2];
  logic [7:0] saved [8];
  logic [7:0] mode_exp [4] = '{8'h00, 8'h45, 8'h92, 8'h03};
  // Kinds: 0 reg write, 1 reg read, 2 port write, 3 port read, 4 port read unchecked, 5 step
  dss_row_s rows [] = '{
    '{1, 12'h210, 8'h00}, '{1, 12'h358, 8'h00}, '{1, 12'h374, 8'h00},
    '{2, 12'h00C, 8'h00}, '{2, 12'h00B, 8'h45}, '{2, 12'h00B, 8'h56},
    '{2, 12'h003, 8'h02}, '{2, 12'h003, 8'h00}, '{2, 12'h005, 8'h01}, '{2, 12'h005, 8'h00},
    '{4, 12'h00E, 8'h00}, '{3, 12'h00B, 8'h00}, '{3, 12'h00B, 8'h45},
    '{3, 12'h00B, 8'h56}, '{3, 12'h00B, 8'h00},
    '{2, 12'h00F, 8'h01}, '{3, 12'h00F, 8'h01},
    '{2, 12'h0D6, 8'hC4}, '{2, 12'h0D6, 8'hC7}, '{4, 12'h0DC, 8'h00},
    '{3, 12'h0D6, 8'hC4}, '{3, 12'h0D6, 8'h00}, '{3, 12'h0D6, 8'h00},
    '{3, 12'h0D6, 8'hC7}, '{2, 12'h0DE, 8'h0A}, '{3, 12'h0DE, 8'h0A},
    '{1, 12'h210, 8'h02}, '{5, 12'h000, 8'h02}, '{5, 12'h000, 8'h02},
    '{5, 12'h000, 8'h02}, '{1, 12'h210, 8'h00},
    '{3, 12'h003, 8'hFF}, '{3, 12'h003, 8'hFF},
    '{5, 12'h000, 8'h04}, '{5, 12'h000, 8'h04}, '{3, 12'h005, 8'h01}, '{3, 12'h005, 8'h00},
    '{4, 12'h001, 8'h00}, '{1, 12'h358, 8'h20}, '{2, 12'h00C, 8'h00},
    '{1, 12'h358, 8'h00}, '{4, 12'h0C2, 8'h00}, '{1, 12'h210, 8'h10},
    '{2, 12'h0D8, 8'h00}, '{1, 12'h210, 8'h00}
  };
  dss_top i_dss_top (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
    .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
    .dma_request_in(dma_request_in), .dma_step_in(dma_step_in),
    .dma_request_out(dma_request_out), .terminal_count_out(terminal_count_out),
    .dma_halt_out(dma_halt_out), .mgmt_interrupt_out(mgmt_interrupt_out),
    .dma_local_cycle_in(dma_local_cycle_in),
    .local_device_claim_n_in(local_device_claim_n_in),
    .address_strobe_n_out(address_strobe_n_out), .data_buffer_en_out(data_buffer_en_out));
  dss_periph_model i_dss_periph_model (.clk_in(clk_in), .rst_in(rst_in), .want_in(want),
    .terminal_count_in(terminal_count_out), .dma_local_cycle_in(dma_local_cycle_in),
    .claim_delay_in(2'h0), .dma_request_out(dma_request_in),
    .local_device_claim_n_out(local_device_claim_n_in));
  initial
  begin
    forever #2 clk_in = ~clk_in;
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic io(logic w, logic [9:0] a, logic [7:0] d);
    @(posedge clk_in);
    io_wr_in <= w;
    io_rd_in <= !w;
    io_addr_in <= a;
    io_wdata_in <= d;
    @(posedge clk_in);
    io_wr_in <= 1'b0;
    io_rd_in <= 1'b0;
    #1 rd = {24'h0, io_rdata_out};
  endtask
  task automatic step(logic [7:0] m);
    @(posedge clk_in);
    dma_step_in <= m;
    @(posedge clk_in);
    dma_step_in <= 8'h00;
  endtask
  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i])
    begin
      case (rows[i].k)
        0: apb(1'b1, rows[i].a, {24'h0, rows[i].d});
        1: apb(1'b0, rows[i].a, 32'h0);
        2: io(1'b1, rows[i].a[9:0], rows[i].d);
        5: step(rows[i].d);
        default: io(1'b0, rows[i].a[9:0], 8'h00);
      endcase
      if (rows[i].k == 1 || rows[i].k == 3)
        check($sformatf("row %0d", i), rd, {24'h0, rows[i].d});
    end
    $display("table test done");
    apb(1'b0, 12'h3FC, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    want <= 8'h08;
    apb(1'b1, 12'h358, 32'h40);
    repeat (4) @(posedge clk_in);
    #1 check("trap interrupt", 32'(mgmt_interrupt_out), 32'h1);
    check("request blocked", 32'(dma_request_out), 32'h0);
    step(8'h08);
    apb(1'b1, 12'h374, 32'h10);
    apb(1'b0, 12'h374, 32'h0);
    check("trapped again", rd, 32'h10);
    apb(1'b1, 12'h358, 32'h0);
    apb(1'b1, 12'h374, 32'h10);
    apb(1'b0, 12'h374, 32'h0);
    check("event cleared", rd, 32'h0);
    check("request resumed", 32'(dma_request_out), 32'h08);
    $display("trap test done");
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, 12'h358, 32'(s * 8));
      @(posedge clk_in);
      dma_local_cycle_in <= 1'b1;
      n = 0;
      while (data_buffer_en_out !== 1'b1 && n < 9)
      begin
        @(posedge clk_in);
        #1 n++;
      end
      nl[s] = n;
      @(posedge clk_in);
      dma_local_cycle_in <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    check("strobe sampled", 32'(nl[0]), 32'd2);
    check("early sample", 32'(nl[0] - nl[1]), 32'd1);
    $display("local bus test done");
    // Autoinit base recovery: read mid count, then a verify run reloads it
    step(8'h04);
    for (int b = 0; b < 2; b++)
    begin
      io(1'b0, 10'h005, 8'h00);
      check("mid count", rd, 32'h0);
    end
    io(1'b1, IO_LOW_MODE, 8'h92);
    step(8'h04);
    io(1'b0, 10'h005, 8'h00);
    check("base count low", rd, 32'h1);
    io(1'b0, 10'h005, 8'h00);
    check("base count high", rd, 32'h0);
    $display("base recovery test done");
    // Suspend: stop, save modes, masks, progress, pointers, counts
    apb(1'b1, 12'h358, 32'h40);
    io(1'b0, 10'h003, 8'h00);
    io(1'b0, IO_LOW_RB_RESET, 8'h00);
    for (int b = 0; b < 4; b++)
    begin
      io(1'b0, IO_LOW_MODE, 8'h00);
      saved[b] = rd[7:0];
    end
    io(1'b0, IO_LOW_MASK_ALL, 8'h00);
    saved[4] = rd[7:0];
    check("saved mask", rd, 32'h3);
    apb(1'b0, 12'h210, 32'h0);
    check("saved progress", rd, 32'h08);
    apb(1'b0, 12'h358, 32'h0);
    saved[5] = rd[7:0];
    check("saved pointer", rd, 32'h60);
    io(1'b1, IO_LOW_PTR_CLR, 8'h00);
    io(1'b1, IO_HIGH_PTR_CLR, 8'h00);
    io(1'b0, 10'h005, 8'h00);
    saved[6] = rd[7:0];
    check("saved count", rd, 32'h1);
    io(1'b0, 10'h005, 8'h00);
    saved[7] = rd[7:0];
    // Power loss in mid-run
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, 12'h210, 32'h0);
    check("reset progress", rd, 32'h0);
    apb(1'b0, 12'h358, 32'h0);
    check("reset control", rd, 32'h0);
    apb(1'b0, 12'h374, 32'h0);
    check("reset event", rd, 32'h0);
    // Resume: modes and masks, counts, then re-set a saved pointer
    for (int b = 0; b < 4; b++)
      io(1'b1, IO_LOW_MODE, {saved[b][7:2], 2'(b)});
    io(1'b1, IO_LOW_MASK_ALL, saved[4]);
    io(1'b1, 10'h005, saved[6]);
    io(1'b1, 10'h005, saved[7]);
    if (saved[5][CTRL_PTR_LOW_BIT])
      io(1'b0, 10'h001, 8'h00);
    apb(1'b0, 12'h358, 32'h0);
    check("restored pointer", rd, 32'h20);
    io(1'b0, IO_LOW_RB_RESET, 8'h00);
    for (int b = 0; b < 4; b++)
    begin
      io(1'b0, IO_LOW_MODE, 8'h00);
      check("restored mode", rd, {24'h0, mode_exp[b]});
    end
    io(1'b0, IO_LOW_MASK_ALL, 8'h00);
    check("restored mask", rd, 32'h3);
    io(1'b1, IO_LOW_PTR_CLR, 8'h00);
    io(1'b0, 10'h005, 8'h00);
    check("restored count", rd, 32'h1);
    $display("suspend test done");
    print_verdict();
  end
endmodule
